/* File: hw/gpio_port_with_irq_packet.sv */
// Strobed register access was left to the implementer.
`default_nettype none
module gpio_port_with_irq_packet (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic [gpio_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [gpio_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output var  logic [gpio_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic [gpio_pkg::NPIN-1:0]     pin_in,
  output var  logic [gpio_pkg::NPIN-1:0]     pin_out,
  output var  logic [gpio_pkg::NPIN-1:0]     pin_oe,
  input  wire logic [gpio_pkg::NPIN-1:0]     alt_out,
  input  wire logic [gpio_pkg::NPIN-1:0]     alt_oe,
  input  wire logic                          break_evt,
  input  wire logic                          framing_evt,
  input  wire logic                          parity_evt,
  input  wire logic                          overrun_evt,
  input  wire logic                          ring_lvl,
  input  wire logic                          dsr_lvl,
  input  wire logic                          dcd_lvl,
  output var  logic                          pkt_valid,
  output var  logic [7:0]                    pkt_data,
  output var  logic                          pkt_last,
  input  wire logic                          pkt_ready
);
  import gpio_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [9:0] alt_map(input logic [2:0] f);
    logic [9:0] m;
    m = 10'h000;
    case (f)
      FUNC_RTS_CTS:   m = ALT_RTS_CTS;
      FUNC_DTR_DSR:   m = ALT_DTR_DSR;
      FUNC_XCVR_ACT:  m = ALT_XCVR;
      FUNC_XCVR_ADDR: m = ALT_XCVR;
      // Reserved codes leave every pin as general purpose
      default:        m = 10'h000;
    endcase
    return m;
  endfunction

  function automatic logic [7:0] pkt_byte(
    input logic       cus,
    input logic [3:0] i,
    input logic [9:0] st,
    input logic [9:0] ch,
    input logic [3:0] er,
    input logic [2:0] ln
  );
    logic [7:0] b;
    b = 8'h00;
    if (cus) begin
      case (i)
        4'h0:    b = st[7:0];
        4'h1:    b = {6'h00, st[9:8]};
        4'h2:    b = ch[7:0];
        4'h3:    b = {6'h00, ch[9:8]};
        4'h4:    b = {4'h0, er};
        default: b = 8'h00;
      endcase
    end else begin
      case (i)
        4'h0:    b = STD_REQ_TYPE;
        4'h1:    b = STD_NOTIFY;
        4'h6:    b = STD_LEN_LO;
        4'h8:    b = {1'b0, er[ERR_OVR], er[ERR_PAR], er[ERR_FRM],
                      ln[2], er[ERR_BRK], ln[1], ln[0]};
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  logic [9:0] prev_q;
  logic [2:0] func_q;
  logic [9:0] dir_q;
  logic [9:0] latch_q;
  logic [9:0] latch_d;
  logic [9:0] mask_q;
  logic [1:0] fmt_q;
  logic [9:0] chg_q;
  logic [9:0] chg_d;
  logic [3:0] err_q;
  logic [3:0] err_d;
  logic       brk_req_q;
  logic       brk_req_d;
  pkt_state_t state_q;
  logic [3:0] idx_q;
  logic       cus_q;
  logic [9:0] snap_st_q;
  logic [9:0] snap_ch_q;
  logic [3:0] snap_er_q;
  logic [2:0] snap_ln_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  wire wr_func  = reg_wr && (reg_addr == OFS_PIN_FUNC);
  wire wr_dir   = reg_wr && (reg_addr == OFS_PIN_DIRECTION);
  wire wr_set   = reg_wr && (reg_addr == OFS_OUTPUT_SET_STROBE);
  wire wr_clr   = reg_wr && (reg_addr == OFS_OUTPUT_CLEAR_STROBE);
  wire wr_level = reg_wr && (reg_addr == OFS_PIN_LEVEL);
  wire wr_mask  = reg_wr && (reg_addr == OFS_CHANGE_IRQ_MASK);
  wire wr_fmt   = reg_wr && (reg_addr == OFS_IRQ_PACKET_FORMAT_CTL);

  wire [9:0] alt_sel  = alt_map(func_q);
  wire [9:0] gpio_out = ~alt_sel & dir_q;
  wire [9:0] oe_d     = (alt_sel & alt_oe) | (~alt_sel & dir_q);
  wire [9:0] out_d    = (alt_sel & alt_out) | (~alt_sel & latch_q);
  // Every pin that is not driving counts as an input, gpio or not
  wire [9:0] is_input = ~pin_oe;
  wire [9:0] trig     = (sync2_q ^ prev_q) & is_input & ~mask_q;

  wire [15:0] wd = reg_wdata;
  wire [9:0]  w10 = wd[9:0];
  // Reserved upper bits are dropped; writes there are the master's fault

  // Only one strobe lands per cycle on this bus, so branch order is moot
  always_comb begin
    latch_d = latch_q;
    if (wr_set) begin
      latch_d = latch_q | (w10 & gpio_out);
    end
    if (wr_clr) begin
      latch_d = latch_q & ~(w10 & gpio_out);
    end
    if (wr_level) begin
      latch_d = (latch_q & ~gpio_out) | (w10 & gpio_out);
    end
  end

  wire take = (state_q == ST_IDLE) &&
              ((|chg_q) || brk_req_q || (|err_q[3:1]));

  // New events in the snapshot cycle survive into the next packet
  always_comb begin
    chg_d = (take ? 10'h000 : chg_q) | trig;
    err_d = (take ? 4'h0 : err_q) |
            {overrun_evt, parity_evt, framing_evt, break_evt};
    brk_req_d = (take ? 1'b0 : brk_req_q) |
                (break_evt & fmt_q[FMT_BRK_EN_BIT]);
  end

  wire [3:0] len      = cus_q ? CUS_LEN : STD_LEN;
  wire       at_last  = (idx_q == len - 4'h1);
  wire       advance  = (state_q == ST_SEND) && pkt_ready;
  wire [3:0] idx_nxt  = idx_q + 4'h1;
  wire [7:0] byte_nxt = pkt_byte(cus_q, idx_nxt, snap_st_q, snap_ch_q,
                                 snap_er_q, snap_ln_q);
  wire [7:0] byte_0   = pkt_byte(cus_q, 4'h0, snap_st_q, snap_ch_q,
                                 snap_er_q, snap_ln_q);

  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr)
      OFS_PIN_FUNC:              rd_mux = {13'h0000, func_q};
      OFS_PIN_DIRECTION:         rd_mux = {6'h00, dir_q};
      OFS_PIN_LEVEL:             rd_mux = {6'h00, sync2_q};
      OFS_CHANGE_IRQ_MASK:       rd_mux = {6'h00, mask_q};
      OFS_IRQ_PACKET_FORMAT_CTL: rd_mux = {14'h0000, fmt_q};
      default:                   rd_mux = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
      prev_q  <= 10'h000;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      func_q  <= RST_PIN_FUNC[2:0];
      dir_q   <= RST_DIRECTION;
      mask_q  <= RST_MASK;
      fmt_q   <= RST_FORMAT;
      latch_q <= RST_LATCH;
    end else begin
      if (wr_func) func_q <= wd[2:0];
      if (wr_dir) dir_q <= w10;
      if (wr_mask) mask_q <= w10;
      if (wr_fmt) fmt_q <= wd[1:0];
      latch_q <= latch_d;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_out   <= 10'h000;
      pin_oe    <= 10'h000;
      reg_rdata <= 16'h0000;
    end else begin
      pin_out   <= out_d;
      pin_oe    <= oe_d;
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chg_q     <= 10'h000;
      err_q     <= 4'h0;
      brk_req_q <= 1'b0;
    end else begin
      chg_q     <= chg_d;
      err_q     <= err_d;
      brk_req_q <= brk_req_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Packet engine

  // Snapshot freezes the packet so pins moving mid-send cannot tear it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cus_q     <= 1'b0;
      snap_st_q <= 10'h000;
      snap_ch_q <= 10'h000;
      snap_er_q <= 4'h0;
      snap_ln_q <= 3'h0;
    end else if (take) begin
      cus_q     <= fmt_q[FMT_CUSTOM_BIT];
      snap_st_q <= sync2_q;
      snap_ch_q <= chg_q;
      snap_er_q <= err_q;
      snap_ln_q <= {ring_lvl, dsr_lvl, dcd_lvl};
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_IDLE;
      idx_q     <= 4'h0;
      pkt_valid <= 1'b0;
      pkt_data  <= 8'h00;
      pkt_last  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) state_q <= ST_LOAD;
        end
        ST_LOAD: begin
          state_q   <= ST_SEND;
          idx_q     <= 4'h0;
          pkt_valid <= 1'b1;
          pkt_data  <= byte_0;
          pkt_last  <= 1'b0;
        end
        ST_SEND: begin
          if (advance) begin
            if (at_last) begin
              state_q   <= ST_IDLE;
              pkt_valid <= 1'b0;
              pkt_data  <= 8'h00;
              pkt_last  <= 1'b0;
            end else begin
              idx_q    <= idx_nxt;
              pkt_data <= byte_nxt;
              pkt_last <= (idx_nxt == len - 4'h1);
            end
          end
        end
        default: begin
          state_q   <= ST_IDLE;
          pkt_valid <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_dir_gpio;
    @(posedge sys_clk) disable iff (rst)
    ##1 ((pin_oe & ~$past(alt_sel)) == ($past(dir_q) & ~$past(alt_sel)));
  endproperty
  a_dir_gpio: assert property (p_dir_gpio)
    else $error("gpio direction not applied");

  property p_dir_alt;
    @(posedge sys_clk) disable iff (rst)
    ##1 ((pin_oe & $past(alt_sel)) == ($past(alt_oe) & $past(alt_sel)));
  endproperty
  a_dir_alt: assert property (p_dir_alt)
    else $error("alternate pin direction wrong");

  property p_set;
    @(posedge sys_clk) disable iff (rst)
    wr_set |=> ((latch_q & $past(w10 & gpio_out)) == $past(w10 & gpio_out));
  endproperty
  a_set: assert property (p_set)
    else $error("set write did not raise latch");

  property p_clr;
    @(posedge sys_clk) disable iff (rst)
    wr_clr |=> ((latch_q & $past(w10 & gpio_out)) == 10'h000);
  endproperty
  a_clr: assert property (p_clr)
    else $error("clear write did not lower latch");

  property p_guard;
    @(posedge sys_clk) disable iff (rst)
    (wr_set || wr_clr) |=> (((latch_q ^ $past(latch_q)) &
                           ~$past(w10 & gpio_out)) == 10'h000);
  endproperty
  a_guard: assert property (p_guard)
    else $error("set or clear touched a protected pin");

  property p_read_level;
    @(posedge sys_clk) disable iff (rst)
    (reg_rd && reg_addr == OFS_PIN_LEVEL) |=>
      (reg_rdata == {6'h00, $past(sync2_q)});
  endproperty
  a_read_level: assert property (p_read_level)
    else $error("level read mismatch");

  property p_level_wr;
    @(posedge sys_clk) disable iff (rst)
    wr_level |=> ((latch_q & $past(gpio_out)) == $past(w10 & gpio_out));
  endproperty
  a_level_wr: assert property (p_level_wr)
    else $error("level write not applied");

  property p_change_pkt;
    @(posedge sys_clk) disable iff (rst)
    ((|trig) && state_q == ST_IDLE) |-> ##[1:2] (state_q == ST_LOAD);
  endproperty
  a_change_pkt: assert property (p_change_pkt)
    else $error("unmasked change raised no packet");

  property p_std_head;
    @(posedge sys_clk) disable iff (rst)
    (state_q == ST_LOAD && !cus_q) |=>
      (pkt_valid && pkt_data == STD_REQ_TYPE);
  endproperty
  a_std_head: assert property (p_std_head)
    else $error("standard header byte wrong");

  property p_cus_head;
    @(posedge sys_clk) disable iff (rst)
    (state_q == ST_LOAD && cus_q) |=>
      (pkt_valid && pkt_data == snap_st_q[7:0]);
  endproperty
  a_cus_head: assert property (p_cus_head)
    else $error("custom first byte wrong");

  property p_chg_clear;
    @(posedge sys_clk) disable iff (rst)
    (take && !(|trig)) |=> (chg_q == 10'h000);
  endproperty
  a_chg_clear: assert property (p_chg_clear)
    else $error("change flags kept after snapshot");

  c_std_done: cover property (@(posedge sys_clk) disable iff (rst)
    advance && at_last && !cus_q);
  c_cus_done: cover property (@(posedge sys_clk) disable iff (rst)
    advance && at_last && cus_q);
  c_break_pkt: cover property (@(posedge sys_clk) disable iff (rst)
    take && brk_req_q);
endmodule // gpio_port_with_irq_packet
`default_nettype wire

/* File: shared/gpio_pkg.sv */
`default_nettype none
package gpio_pkg;
  localparam int NPIN = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // Register offsets
  localparam logic [7:0] OFS_PIN_FUNC = 8'h0c;
  localparam logic [7:0] OFS_PIN_DIRECTION = 8'h0d;
  localparam logic [7:0] OFS_OUTPUT_SET_STROBE = 8'h0e;
  localparam logic [7:0] OFS_OUTPUT_CLEAR_STROBE = 8'h0f;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h10;
  localparam logic [7:0] OFS_CHANGE_IRQ_MASK = 8'h11;
  localparam logic [7:0] OFS_IRQ_PACKET_FORMAT_CTL = 8'h12;
  // Reset values
  localparam logic [9:0] RST_PIN_FUNC = 10'h000;
  localparam logic [9:0] RST_DIRECTION = 10'h000;
  localparam logic [9:0] RST_LATCH = 10'h000;
  localparam logic [9:0] RST_MASK = 10'h100;
  localparam logic [1:0] RST_FORMAT = 2'h0;
  // Format control fields
  localparam int FMT_CUSTOM_BIT = 0;
  localparam int FMT_BRK_EN_BIT = 1;
  // Pin function selector values and the pins they take over
  localparam logic [2:0] FUNC_GPIO = 3'h0;
  localparam logic [2:0] FUNC_RTS_CTS = 3'h1;
  localparam logic [2:0] FUNC_DTR_DSR = 3'h2;
  localparam logic [2:0] FUNC_XCVR_ACT = 3'h3;
  localparam logic [2:0] FUNC_XCVR_ADDR = 3'h4;
  localparam logic [9:0] ALT_RTS_CTS = 10'h030;
  localparam logic [9:0] ALT_DTR_DSR = 10'h00c;
  localparam logic [9:0] ALT_XCVR = 10'h020;
  // Line status flag positions
  localparam int ERR_BRK = 0;
  localparam int ERR_FRM = 1;
  localparam int ERR_PAR = 2;
  localparam int ERR_OVR = 3;
  // Notification packet
  localparam logic [7:0] STD_REQ_TYPE = 8'ha1;
  localparam logic [7:0] STD_NOTIFY = 8'h20;
  localparam logic [7:0] STD_LEN_LO = 8'h02;
  localparam logic [3:0] STD_LEN = 4'ha;
  localparam logic [3:0] CUS_LEN = 4'h5;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SEND = 2'b10
  } pkt_state_t;
endpackage
`default_nettype wire

/* File: verif/gpio_port_with_irq_packet_tb.sv */
`default_nettype none
module gpio_port_with_irq_packet_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gpio_pkg::*;
  logic        sys_clk, rst, reg_wr, reg_rd, pkt_valid, pkt_last, pkt_ready, slow;
  logic [7:0]  reg_addr, pkt_data;
  logic [15:0] reg_wdata, reg_rdata;
  logic [9:0]  pin_in, pin_out, pin_oe, alt_out, alt_oe, ext_in, dir_m, lat_m, mask_m;
  logic [3:0]  evt;
  logic [2:0]  func_m;
  logic [1:0]  fmt_m;
  logic        ring_lvl, dsr_lvl, dcd_lvl;
  int          failures, checked, cycles;
  int unsigned seed = 30;
  // The bench resolves each pad: driven value while enabled, outside level otherwise
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_in);
  gpio_port_with_irq_packet dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out),
    .alt_oe(alt_oe), .break_evt(evt[0]), .framing_evt(evt[1]), .parity_evt(evt[2]),
    .overrun_evt(evt[3]), .ring_lvl(ring_lvl), .dsr_lvl(dsr_lvl), .dcd_lvl(dcd_lvl),
    .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_ready(pkt_ready));
  usb_host_model host (.sys_clk(sys_clk), .rst(rst), .slow(slow), .pkt_valid(pkt_valid),
    .pkt_data(pkt_data), .pkt_last(pkt_last), .pkt_ready(pkt_ready));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  function automatic logic [9:0] alt_m();
    case (func_m)
      3'h1: return 10'h030;
      3'h2: return 10'h00c;
      3'h3, 3'h4: return 10'h020;
      default: return 10'h000;
    endcase
  endfunction
  function automatic logic [15:0] reg_m(input logic [7:0] a);
    case (a)
      OFS_PIN_FUNC: return {13'h0, func_m};
      OFS_PIN_DIRECTION: return {6'h0, dir_m};
      OFS_PIN_LEVEL: return {6'h0, pin_in};
      OFS_CHANGE_IRQ_MASK: return {6'h0, mask_m};
      OFS_IRQ_PACKET_FORMAT_CTL: return {14'h0, fmt_m};
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic [7:0] std_d(input logic [3:0] e);
    return {1'b0, e[3], e[2], e[1], ring_lvl, e[0], dsr_lvl, dcd_lvl};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [9:0] g;
    g = dir_m & ~alt_m();
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    case (a)
      OFS_PIN_FUNC: func_m = d[2:0];
      OFS_PIN_DIRECTION: dir_m = d[9:0];
      OFS_OUTPUT_SET_STROBE: lat_m = lat_m | (d[9:0] & g);
      OFS_OUTPUT_CLEAR_STROBE: lat_m = lat_m & ~(d[9:0] & g);
      OFS_PIN_LEVEL: lat_m = (lat_m & ~g) | (d[9:0] & g);
      OFS_CHANGE_IRQ_MASK: mask_m = d[9:0];
      OFS_IRQ_PACKET_FORMAT_CTL: fmt_m = d[1:0];
      default: ;
    endcase
    // Let an edge pass so a following write never reassigns the strobe at once
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    check(reg_rdata, exp);
    @(posedge sys_clk);
  endtask
  task automatic pins();
    logic [9:0] am, oe;
    repeat (3) @(posedge sys_clk);
    am = alt_m();
    oe = (dir_m & ~am) | (alt_oe & am);
    @(negedge sys_clk);
    check({6'h0, pin_oe}, {6'h0, oe});
    check({6'h0, pin_out & oe}, {6'h0, ((lat_m & ~am) | (alt_out & am)) & oe});
    @(posedge sys_clk);
  endtask
  task automatic get_pkt(input logic [7:0] exp[$]);
    int n;
    n = 0;
    while (host.rx_q.size() < exp.size() && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (8) @(posedge sys_clk);
    check(16'(host.rx_q.size()), 16'(exp.size()));
    foreach (exp[j]) begin
      check({7'h0, host.rx_q[j]}, {7'h0, j == exp.size() - 1, exp[j]});
    end
    host.rx_q.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever begin
      #10 sys_clk = ~sys_clk;
    end
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    logic [15:0] r;
    rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, evt, slow} = '0;
    {ext_in, alt_out, alt_oe, ring_lvl, dsr_lvl, dcd_lvl} = '0;
    {dir_m, lat_m, func_m, fmt_m} = '0;
    mask_m = 10'h100;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int a = 8'h0b; a <= 8'h13; a++) rd(8'(a), reg_m(8'(a)));
    $display("reset values done");
    wr(OFS_CHANGE_IRQ_MASK, 16'h03ff);
    for (int i = 0; i < 50; i++) begin
      r = rnd();
      alt_out <= 10'(rnd());
      alt_oe <= 10'(rnd());
      ext_in <= 10'(rnd());
      case (i % 5)
        0: wr(OFS_PIN_FUNC, r & 16'h0007);
        1: wr(OFS_PIN_DIRECTION, r & 16'h03ff);
        2: wr(OFS_OUTPUT_SET_STROBE, r & 16'h03ff);
        3: wr(OFS_OUTPUT_CLEAR_STROBE, r & 16'h03ff);
        default: wr(OFS_PIN_LEVEL, r & 16'h03ff);
      endcase
      pins();
      rd(OFS_PIN_LEVEL, {6'h0, pin_in});
    end
    wr(8'h13, 16'hffff);
    wr(OFS_IRQ_PACKET_FORMAT_CTL, 16'h0002);
    for (int a = 8'h0b; a <= 8'h13; a++) rd(8'(a), reg_m(8'(a)));
    $display("pin control done");
    slow <= 1'b1;
    {ring_lvl, dsr_lvl, dcd_lvl} <= 3'(rnd());
    wr(OFS_PIN_FUNC, 16'h0000);
    wr(OFS_PIN_DIRECTION, 16'h0000);
    wr(OFS_IRQ_PACKET_FORMAT_CTL, 16'h0000);
    ext_in <= 10'h000;
    repeat (10) @(posedge sys_clk);
    host.rx_q.delete();
    wr(OFS_CHANGE_IRQ_MASK, 16'h0100);
    ext_in <= 10'h008;
    get_pkt('{8'ha1, 8'h20, 0, 0, 0, 0, 8'h02, 0, std_d(4'h0), 0});
    wr(OFS_IRQ_PACKET_FORMAT_CTL, 16'h0001);
    ext_in <= 10'h10c;
    get_pkt('{8'h0c, 8'h01, 8'h04, 8'h00, 8'h00});
    ext_in <= 10'h30c;
    get_pkt('{8'h0c, 8'h03, 8'h00, 8'h02, 8'h00});
    // Pin 4 becomes an alternate input; its change must still raise a packet
    alt_oe <= 10'h000;
    wr(OFS_PIN_FUNC, 16'h0001);
    ext_in <= 10'h31c;
    get_pkt('{8'h1c, 8'h03, 8'h10, 8'h00, 8'h00});
    $display("change packets done");
    evt <= 4'h1;
    @(posedge sys_clk);
    evt <= 4'h0;
    repeat (40) @(posedge sys_clk);
    check(16'(host.rx_q.size()), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_IRQ_PACKET_FORMAT_CTL, 16'(2 + (i % 2)));
      evt <= 4'(1 << i);
      @(posedge sys_clk);
      evt <= 4'h0;
      if (i % 2 == 0) begin
        get_pkt('{8'ha1, 8'h20, 0, 0, 0, 0, 8'h02, 0, std_d(4'(1 << i)), 0});
      end else begin
        get_pkt('{8'h1c, 8'h03, 8'h00, 8'h00, {4'h0, 4'(1 << i)}});
      end
    end
    $display("line event packets done");
    conclude();
  end
endmodule // gpio_port_with_irq_packet_tb
`default_nettype wire

/* File: verif/usb_host_model.sv */
`default_nettype none
module usb_host_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       pkt_valid,
  input  wire logic [7:0] pkt_data,
  input  wire logic       pkt_last,
  output var  logic       pkt_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] rx_q[$];
  logic [1:0] cnt_q;
  ////////////////////////////////////////////////////////////////////////
  // Slow mode takes one byte in four, so every byte must stand across stalls
  // Plain always: the bench empties the queue between packets
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      if (pkt_valid && pkt_ready) begin
        rx_q.push_back({pkt_last, pkt_data});
      end
    end
  end
  assign pkt_ready = !slow || (cnt_q == 2'h0);
endmodule // usb_host_model
`default_nettype wire
